//--- rtl/rfa_aligner.sv
// Purpose: Header search, nibble alignment, frame pulse and parity
// Assumes: Serial clock at most a quarter of the core clock rate
// Notes: Serial stream cannot stall; a full buffer drops words
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////
module rfa_aligner #(
  parameter int FIFO_DEPTH = rfa_pkg::FIFO_DEPTH,
  parameter logic [6:0] DEV_ADDR = rfa_pkg::DEV_ADDR_DEF
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_rx_serial_clock,
  input wire logic i_rx_serial_data,
  input wire logic i_align_enable_in,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_rx_ready,
  output logic [3:0] o_rx_parallel_data,
  output logic o_rx_valid,
  output logic o_frame_pulse_out,
  output logic o_rx_parity_out
);
  localparam int W = rfa_pkg::WORD_W;
  rfa_reg_if rb ();
  logic sclk_s1_ff, sclk_s2_ff, sclk_d_ff, sdat_s1_ff, sdat_s2_ff;
  logic aen_s1_ff, aen_s2_ff, aen_d_ff;
  logic [31:0] hdr_ff, nxt_hdr, msk_ff, nxt_msk, sh_ff, nxt_sh;
  logic [7:0] dmx_ff, nxt_dmx, rxout_ff, nxt_rxout;
  logic ovf_ff, nxt_ovf, armed_ff, nxt_armed;
  logic [1:0] bp_ff, nxt_bp;
  logic bit_tick, aen, match, emit, fp, drop;
  logic fifo_wready, fifo_rvalid, fifo_rready;
  logic [W-1:0] fifo_wdata, fifo_rdata;
  logic [3:0] dat_ff, nxt_dat;
  logic val_ff, nxt_val, fpo_ff, nxt_fpo, par_ff, nxt_par;

  ////////////////////////////////////////////////////////////////////
  rfa_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_port (
    .i_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_oe(o_sda_oe),
    .rb(rb.master)
  );

  rfa_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_wvalid(emit),
    .o_wready(fifo_wready),
    .i_wdata(fifo_wdata),
    .o_rvalid(fifo_rvalid),
    .i_rready(fifo_rready),
    .o_rdata(fifo_rdata)
  );

  // Open drain: only ever pulls low
  assign o_sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////
  // Input synchronisers; link clock edges found by sampling
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      {sclk_s1_ff, sclk_s2_ff, sclk_d_ff} <= 3'h0;
      {sdat_s1_ff, sdat_s2_ff} <= 2'h0;
      {aen_s1_ff, aen_s2_ff, aen_d_ff} <= 3'h0;
    end
    else
    begin
      {sclk_s1_ff, sclk_s2_ff, sclk_d_ff} <= {i_rx_serial_clock, sclk_s1_ff, sclk_s2_ff};
      {sdat_s1_ff, sdat_s2_ff} <= {i_rx_serial_data, sdat_s1_ff};
      {aen_s1_ff, aen_s2_ff} <= {i_align_enable_in, aen_s1_ff};
      aen_d_ff <= aen;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register file
  always_comb
  begin
    nxt_hdr = hdr_ff;
    nxt_msk = msk_ff;
    nxt_dmx = dmx_ff;
    nxt_rxout = rxout_ff;
    nxt_ovf = ovf_ff;
    rb.rdata = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      if (rb.addr == 8'(rfa_pkg::ADR_HDR3 + i))
      begin
        rb.rdata = hdr_ff[8*(3-i) +: 8];
        if (rb.wr)
          nxt_hdr[8*(3-i) +: 8] = rb.wdata;
      end
      if (rb.addr == 8'(rfa_pkg::ADR_MSK3 + i))
      begin
        rb.rdata = msk_ff[8*(3-i) +: 8];
        if (rb.wr)
          nxt_msk[8*(3-i) +: 8] = rb.wdata;
      end
    end
    if (rb.addr == rfa_pkg::ADR_DMX)
    begin
      rb.rdata = dmx_ff;
      if (rb.wr)
        nxt_dmx = rb.wdata;
    end
    if (rb.addr == rfa_pkg::ADR_RXOUT)
    begin
      rb.rdata = rxout_ff;
      if (rb.wr)
        nxt_rxout = rb.wdata;
    end
    if (rb.addr == rfa_pkg::ADR_STAT)
    begin
      rb.rdata[rfa_pkg::ST_ARMED_BIT] = armed_ff;
      rb.rdata[rfa_pkg::ST_OVF_BIT] = ovf_ff;
      if (rb.wr && rb.wdata[rfa_pkg::ST_OVF_BIT])
        nxt_ovf = 1'b0;
    end
    // A drop in the clearing cycle still sets the flag
    if (drop)
      nxt_ovf = 1'b1;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      hdr_ff <= rfa_pkg::HDR_RST;
      msk_ff <= rfa_pkg::MSK_RST;
      dmx_ff <= rfa_pkg::DMX_RST;
      rxout_ff <= rfa_pkg::RXOUT_RST;
      ovf_ff <= 1'b0;
    end
    else
    begin
      hdr_ff <= nxt_hdr;
      msk_ff <= nxt_msk;
      dmx_ff <= nxt_dmx;
      rxout_ff <= nxt_rxout;
      ovf_ff <= nxt_ovf;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Alignment core
  always_comb
  begin
    bit_tick = sclk_s2_ff && !sclk_d_ff;
    aen = dmx_ff[rfa_pkg::DMX_OVR_BIT] ? dmx_ff[rfa_pkg::DMX_EN_BIT] : aen_s2_ff;
    nxt_sh = bit_tick ? {sh_ff[30:0], sdat_s2_ff} : sh_ff;
    match = ((nxt_sh ^ hdr_ff) & ~msk_ff) == 32'h0;
    nxt_bp = bp_ff;
    emit = 1'b0;
    fp = 1'b0;
    if (bit_tick)
    begin
      nxt_bp = bp_ff + 2'h1;
      if (armed_ff && match)
      begin
        // Header low bit just landed; bits 15:12 start the new word
        emit = 1'b1;
        fp = 1'b1;
        nxt_bp = 2'h0;
      end
      else if (bp_ff == 2'h3)
      begin
        emit = 1'b1;
        fp = match;
      end
    end
    fifo_wdata = {fp, nxt_sh[15:12]};
    drop = emit && !fifo_wready;
    nxt_armed = (aen && !aen_d_ff) || (armed_ff && !(fp && !aen));
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sh_ff <= 32'h0;
      bp_ff <= 2'h0;
      armed_ff <= 1'b0;
    end
    else
    begin
      sh_ff <= nxt_sh;
      bp_ff <= nxt_bp;
      armed_ff <= nxt_armed;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output stage; frame flag leaves with exactly one word
  always_comb
  begin
    fifo_rready = !val_ff || i_rx_ready;
    nxt_val = val_ff && !i_rx_ready;
    nxt_dat = dat_ff;
    nxt_fpo = fpo_ff && !i_rx_ready;
    if (fifo_rvalid && fifo_rready)
    begin
      nxt_val = 1'b1;
      nxt_dat = fifo_rdata[3:0];
      nxt_fpo = fifo_rdata[4];
    end
    nxt_par = 1'b0;
    if (rxout_ff[rfa_pkg::PAREN_BIT])
      nxt_par = ^nxt_dat ^ rxout_ff[rfa_pkg::PARINV_BIT];
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      val_ff <= 1'b0;
      dat_ff <= 4'h0;
      fpo_ff <= 1'b0;
      par_ff <= 1'b0;
    end
    else
    begin
      val_ff <= nxt_val;
      dat_ff <= nxt_dat;
      fpo_ff <= nxt_fpo;
      par_ff <= nxt_par;
    end
  end

  assign o_rx_valid = val_ff;
  assign o_rx_parallel_data = dat_ff;
  assign o_frame_pulse_out = fpo_ff;
  assign o_rx_parity_out = par_ff;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  a_masked_realign: assert property (
    (bit_tick && armed_ff && msk_ff == 32'h0000ffff && nxt_sh[31:16] == hdr_ff[31:16])
      |=> bp_ff == 2'h0)
    else $error("masked header did not realign");
  a_hdr_reset: assert property (
    $rose(i_resetn) |-> hdr_ff == rfa_pkg::HDR_RST)
    else $error("header pattern not at reset value");
  a_boundary_kept: assert property (
    (!armed_ff && bit_tick) |=> bp_ff == 2'($past(bp_ff) + 2'h1))
    else $error("boundary moved while search off");
  a_arm_on_rise: assert property (
    (aen && !aen_d_ff) |=> armed_ff)
    else $error("search not armed on enable rise");
  a_disarm_at_fp: assert property (
    (armed_ff && !aen && emit && fp) |=> !armed_ff)
    else $error("search still armed after frame pulse");
  a_fp_one_word: assert property (
    (o_frame_pulse_out && i_rx_ready && !(fifo_rvalid && fifo_rdata[4])) |=> !o_frame_pulse_out)
    else $error("frame pulse outlived its word");
  a_fp_with_data: assert property (
    o_frame_pulse_out |-> o_rx_valid)
    else $error("frame pulse without data word");
  a_hdr_nibble: assert property (
    (armed_ff && match && bit_tick && msk_ff[15:12] == 4'h0) |-> fifo_wdata == {1'b1, hdr_ff[15:12]})
    else $error("first aligned nibble is not header bits 15..12");
  a_parity_value: assert property (
    (o_rx_valid && $stable(rxout_ff) && rxout_ff[rfa_pkg::PAREN_BIT])
      |-> o_rx_parity_out == (^o_rx_parallel_data ^ rxout_ff[rfa_pkg::PARINV_BIT]))
    else $error("parity output wrong");
  a_parity_off: assert property (
    (!rxout_ff[rfa_pkg::PAREN_BIT]) [*2] |-> !o_rx_parity_out)
    else $error("parity output active while disabled");
  a_hdr_write: assert property (
    (rb.wr && rb.addr == rfa_pkg::ADR_HDR3) |=> hdr_ff[31:24] == $past(rb.wdata))
    else $error("header top byte not written");
  a_override: assert property (
    (dmx_ff[rfa_pkg::DMX_OVR_BIT] && !dmx_ff[rfa_pkg::DMX_EN_BIT]) [*2] |-> !aen_d_ff)
    else $error("pin enable leaked through override");

  c_armed_match: cover property (armed_ff && match && bit_tick);
  c_fp_taken: cover property (o_frame_pulse_out && i_rx_ready);
  c_drop: cover property (drop);
  c_disarm: cover property (armed_ff ##1 !armed_ff);
endmodule
`default_nettype wire

//--- rtl/rfa_fifo.sv
// Purpose: Word buffer between aligner and output port
// Assumes: DEPTH is a power of two
// Notes: Flip-flop storage, pointers carry one wrap bit
`timescale 1ns/1ns
`default_nettype none
module rfa_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [WIDTH-1:0] o_rdata
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [AW:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic full, empty;

  always_comb
  begin
    full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    empty = (wp_ff == rp_ff);
    nxt_mem = mem_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    if (i_wvalid && !full)
    begin
      nxt_mem[wp_ff[AW-1:0]] = i_wdata;
      nxt_wp = wp_ff + 1'b1;
    end
    if (i_rready && !empty)
      nxt_rp = rp_ff + 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_ff[i] <= '0;
      wp_ff <= '0;
      rp_ff <= '0;
    end
    else
    begin
      mem_ff <= nxt_mem;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
  end

  assign o_wready = !full;
  assign o_rvalid = !empty;
  assign o_rdata = mem_ff[rp_ff[AW-1:0]];
endmodule
`default_nettype wire

//--- rtl/rfa_i2c_slave.sv
// Purpose: Two-wire serial slave giving byte access to the registers
// Assumes: Bus clock well below a quarter of the core clock
// Notes: Pointer auto-increments after each data byte
`timescale 1ns/1ns
`default_nettype none
module rfa_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = rfa_pkg::DEV_ADDR_DEF
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  rfa_reg_if.master rb
);
  logic scl_s1_ff, scl_s2_ff, scl_d_ff, sda_s1_ff, sda_s2_ff, sda_d_ff;
  rfa_pkg::rfa_i2c_st_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr, tx_ff, nxt_tx;
  logic oe_ff, nxt_oe, wr_ff, nxt_wr;
  logic rise, fall, start, stop;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
    end
    else
    begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= {i_scl, scl_s1_ff, scl_s2_ff};
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= {i_sda, sda_s1_ff, sda_s2_ff};
    end
  end

  always_comb
  begin
    rise = scl_s2_ff && !scl_d_ff;
    fall = !scl_s2_ff && scl_d_ff;
    start = scl_s2_ff && scl_d_ff && sda_d_ff && !sda_s2_ff;
    stop = scl_s2_ff && scl_d_ff && !sda_d_ff && sda_s2_ff;
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_tx = tx_ff;
    nxt_oe = oe_ff;
    nxt_wr = 1'b0;
    nxt_ptr = wr_ff ? ptr_ff + 8'h01 : ptr_ff;
    if (start)
    begin
      nxt_st = rfa_pkg::S_ADDR;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
    end
    else if (stop)
    begin
      nxt_st = rfa_pkg::S_IDLE;
      nxt_oe = 1'b0;
    end
    else if (st_ff != rfa_pkg::S_IDLE && rise)
    begin
      if (cnt_ff != 4'h8)
      begin
        nxt_sh = {sh_ff[6:0], sda_s2_ff};
        nxt_cnt = cnt_ff + 4'h1;
      end
      else
      begin
        nxt_cnt = 4'h0;
        // Master nack ends a read burst
        if (st_ff == rfa_pkg::S_RD && sda_s2_ff)
          nxt_st = rfa_pkg::S_IDLE;
      end
    end
    else if (st_ff != rfa_pkg::S_IDLE && fall)
    begin
      case (cnt_ff)
        4'h8:
        begin
          nxt_oe = 1'b1;
          case (st_ff)
            rfa_pkg::S_ADDR:
            begin
              if (sh_ff[7:1] == DEV_ADDR)
                nxt_st = sh_ff[0] ? rfa_pkg::S_RD : rfa_pkg::S_PTR;
              else
              begin
                nxt_st = rfa_pkg::S_IDLE;
                nxt_oe = 1'b0;
              end
            end
            rfa_pkg::S_PTR:
            begin
              nxt_ptr = sh_ff;
              nxt_st = rfa_pkg::S_WR;
            end
            rfa_pkg::S_WR: nxt_wr = 1'b1;
            default: nxt_oe = 1'b0;
          endcase
        end
        4'h0:
        begin
          nxt_oe = 1'b0;
          if (st_ff == rfa_pkg::S_RD)
          begin
            nxt_tx = rb.rdata;
            nxt_oe = !rb.rdata[7];
            nxt_ptr = ptr_ff + 8'h01;
          end
        end
        default:
          nxt_oe = (st_ff == rfa_pkg::S_RD) && !tx_ff[3'(4'h7 - cnt_ff)];
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_ff <= rfa_pkg::S_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      oe_ff <= 1'b0;
      wr_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      tx_ff <= nxt_tx;
      ptr_ff <= nxt_ptr;
      oe_ff <= nxt_oe;
      wr_ff <= nxt_wr;
    end
  end

  assign o_sda_oe = oe_ff;
  assign rb.wr = wr_ff;
  assign rb.addr = ptr_ff;
  assign rb.wdata = sh_ff;
endmodule
`default_nettype wire

//--- rtl/rfa_pkg.sv
// Purpose: Shared constants for the receive frame aligner
// Assumes: Byte-wide register space reached over a two-wire serial port
// Notes: Offsets are byte addresses of that port
package rfa_pkg;
  // Register offsets
  localparam logic [7:0] ADR_HDR3 = 8'hb0;
  localparam logic [7:0] ADR_HDR0 = 8'hb3;
  localparam logic [7:0] ADR_HDR1 = 8'hb2;
  localparam logic [7:0] ADR_MSK3 = 8'hb4;
  localparam logic [7:0] ADR_MSK0 = 8'hb7;
  localparam logic [7:0] ADR_DMX = 8'hb8;
  localparam logic [7:0] ADR_STAT = 8'hb9;
  localparam logic [7:0] ADR_RXOUT = 8'hd4;
  // Reset values
  localparam logic [31:0] HDR_RST = 32'hf6f62828;
  localparam logic [31:0] MSK_RST = 32'h00000000;
  localparam logic [7:0] DMX_RST = 8'h00;
  localparam logic [7:0] RXOUT_RST = 8'h01;
  // Field positions
  localparam int DMX_EN_BIT = 0;
  localparam int DMX_OVR_BIT = 1;
  localparam int PAREN_BIT = 0;
  localparam int PARINV_BIT = 1;
  localparam int ST_ARMED_BIT = 0;
  localparam int ST_OVF_BIT = 1;
  // Datapath shape
  localparam int NIB_W = 4;
  localparam int WORD_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ADDR = 5'b00010,
    S_PTR = 5'b00100,
    S_WR = 5'b01000,
    S_RD = 5'b10000
  } rfa_i2c_st_t;
endpackage

//--- rtl/rfa_reg_if.sv
// Purpose: Register access carrier between serial port and core
// Assumes: Single clock domain, one-cycle write strobe
// Notes: Read data is combinational from the addressed register
`timescale 1ns/1ns
`default_nettype none
interface rfa_reg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  modport master (output addr, output wdata, output wr, input rdata);
  modport slave (input addr, input wdata, input wr, output rdata);
endinterface
`default_nettype wire

//--- testbench/rfa_framer_model.sv
// Purpose: Framer-side sink for the aligner's word output
// Assumes: One word taken per cycle while ready is high
// Notes: Drives alignment enable; stalls on command
`timescale 1ns/1ns
`default_nettype none
module rfa_framer_model #(
  parameter int FRAME_WORDS = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_arm,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire logic [3:0] i_data,
  input wire logic i_fp,
  input wire logic i_par,
  output logic o_ready,
  output logic o_align_en
);
  logic [5:0] q[$];
  logic seen_ff;
  int cnt;
  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ready <= 1'b0;
      o_align_en <= 1'b0;
      seen_ff <= 1'b0;
      cnt <= 0;
    end
    else
    begin
      o_ready <= !i_stall;
      if (i_valid && o_ready)
      begin
        q.push_back({i_fp, i_par, i_data});
      end
      if (i_arm)
      begin
        o_align_en <= 1'b1;
        seen_ff <= 1'b0;
        cnt <= 0;
      end
      else if (o_align_en && i_valid && o_ready)
      begin
        // Enable held a whole frame past the first pulse, to confirm alignment
        if (i_fp || seen_ff)
        begin
          seen_ff <= 1'b1;
          cnt <= cnt + 1;
        end
        if (cnt == FRAME_WORDS)
        begin
          o_align_en <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Purpose: Self-checking bench for the receive frame aligner
// Assumes: Two-wire register port, serial clock driven only within bursts
// Notes: Words are collected by the framer model's queue
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [6:0] DEV = rfa_pkg::DEV_ADDR_DEF;
  logic clk, rstn, m_scl, m_sda, m_sclk, m_sdat, arm, stall;
  logic sda_oe, sda_out, valid, fp, par, ready, align_en, ack;
  logic [3:0] pdata;
  logic [7:0] v;
  logic [31:0] hdr = 32'hf6f62828;
  wire logic sda_w;
  int error_cnt, n_tests, from;
  // Open drain: the slave only ever pulls low
  assign sda_w = m_sda & ~sda_oe;

  rfa_aligner #(.FIFO_DEPTH(16), .DEV_ADDR(DEV)) rfa_aligner_i (
    .i_ref_clk(clk), .i_resetn(rstn), .i_rx_serial_clock(m_sclk),
    .i_rx_serial_data(m_sdat), .i_align_enable_in(align_en), .i_scl(m_scl),
    .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_rx_ready(ready),
    .o_rx_parallel_data(pdata), .o_rx_valid(valid), .o_frame_pulse_out(fp),
    .o_rx_parity_out(par));
  rfa_framer_model #(.FRAME_WORDS(16)) rfa_framer_model_i (
    .i_clk(clk), .i_resetn(rstn), .i_arm(arm), .i_stall(stall), .i_valid(valid),
    .i_data(pdata), .i_fp(fp), .i_par(par), .o_ready(ready), .o_align_en(align_en));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    if (error_cnt == 0 && n_tests > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task hc;
    repeat (10) @(posedge clk);
  endtask
  task qc;
    repeat (4) @(posedge clk);
  endtask
  task i2c_start;
    m_sda <= 1'b1;
    qc;
    m_scl <= 1'b1;
    hc;
    m_sda <= 1'b0;
    hc;
    m_scl <= 1'b0;
    qc;
  endtask
  task i2c_stop;
    m_sda <= 1'b0;
    hc;
    m_scl <= 1'b1;
    hc;
    m_sda <= 1'b1;
    hc;
  endtask
  task i2c_bit(input logic b, output logic s);
    m_sda <= b;
    hc;
    m_scl <= 1'b1;
    hc;
    s = sda_w;
    m_scl <= 1'b0;
    qc;
  endtask
  // Ninth bit released: slave ack on writes, master nack on reads
  task i2c_byte(input logic [7:0] b, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
    begin
      i2c_bit(b[i], r[i]);
    end
    i2c_bit(1'b1, a);
    a = !a;
  endtask
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    i2c_start;
    i2c_byte({DEV, 1'b0}, v, ack);
    i2c_byte(a, v, ack);
    i2c_byte(d, v, ack);
    i2c_stop;
  endtask
  task reg_rd(input logic [7:0] a, output logic [7:0] d);
    i2c_start;
    i2c_byte({DEV, 1'b0}, d, ack);
    i2c_byte(a, d, ack);
    i2c_start;
    i2c_byte({DEV, 1'b1}, d, ack);
    i2c_byte(8'hff, d, ack);
    i2c_stop;
  endtask
  // Sends the low n bits, most significant first; clock parks low after
  task ser(input logic [63:0] b, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      m_sdat <= b[i];
      m_sclk <= 1'b0;
      repeat (8) @(posedge clk);
      m_sclk <= 1'b1;
      repeat (8) @(posedge clk);
    end
    m_sclk <= 1'b0;
    m_sdat <= !b[0];
    repeat (12) @(posedge clk);
  endtask
  // pc is {invert, enable} of the parity output
  task automatic frame_chk(input int nfp, input logic [3:0] d, input logic [3:0] nd,
                           input logic [1:0] pc);
    int k;
    int n;
    k = -1;
    n = 0;
    for (int i = from; i < rfa_framer_model_i.q.size(); i++)
    begin
      if (rfa_framer_model_i.q[i][5])
      begin
        n++;
        k = (k < 0) ? i : k;
      end
    end
    check("frame pulses", n[7:0], nfp[7:0]);
    if (k >= 0)
    begin
      check("frame nibble", {4'h0, rfa_framer_model_i.q[k][3:0]}, {4'h0, d});
      check("parity", {7'h0, rfa_framer_model_i.q[k][4]}, {7'h0, pc[0] & (^d ^ pc[1])});
      check("next nibble", {4'h0, rfa_framer_model_i.q[k + 1][3:0]}, {4'h0, nd});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
  initial
  begin
    rstn = 1'b0;
    m_scl = 1'b1;
    m_sda = 1'b1;
    m_sclk = 1'b0;
    m_sdat = 1'b0;
    arm = 1'b0;
    stall = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    from = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      reg_rd(8'hb0 + i[7:0], v);
      check("reset value", v, (i < 4) ? hdr[31 - 8 * i -: 8] : 8'h00);
    end
    reg_rd(8'hd4, v);
    check("output control", v, 8'h01);
    reg_rd(8'h10, v);
    check("unmapped read", v, 8'h00);
    reg_wr(8'hb0, 8'h5a);
    reg_rd(8'hb0, v);
    check("header write", v, 8'h5a);
    reg_wr(8'hb0, hdr[31:24]);
    i2c_start;
    i2c_byte({DEV ^ 7'h01, 1'b0}, v, ack);
    i2c_stop;
    check("foreign address ack", {7'h0, ack}, 8'h00);
    check("sda drive level", {7'h0, sda_out}, 8'h00);
    // Register-driven enable, then dropped before the header arrives
    reg_wr(8'hb8, 8'h03);
    reg_rd(8'hb9, v);
    check("armed", v, 8'h01);
    reg_wr(8'hb8, 8'h02);
    from = rfa_framer_model_i.q.size();
    ser({3'b101, 32'hf6f62828, 4'h0}, 39);
    frame_chk(1, 4'h2, 4'h8, 2'b01);
    reg_rd(8'hb9, v);
    check("disarmed", v, 8'h00);
    reg_wr(8'hb8, 8'h00);
    // Low half of the header masked, odd parity, pin enable
    reg_wr(8'hb6, 8'hff);
    reg_wr(8'hb7, 8'hff);
    reg_wr(8'hd4, 8'h03);
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    repeat (10) @(posedge clk);
    from = rfa_framer_model_i.q.size();
    ser({2'b01, 32'hf6f61234, 4'h0}, 38);
    frame_chk(1, 4'h1, 4'h2, 2'b11);
    ser(64'h0, 64);
    ser(64'h0, 8);
    from = rfa_framer_model_i.q.size();
    ser({1'b1, 32'hf6f6abcd, 4'h0}, 37);
    frame_chk(1, 4'ha, 4'hb, 2'b11);
    reg_rd(8'hb9, v);
    check("disarmed by pulse", v, 8'h00);
    from = rfa_framer_model_i.q.size();
    ser({32'hf6f65678, 4'h0}, 36);
    frame_chk(1, 4'h5, 4'h6, 2'b11);
    from = rfa_framer_model_i.q.size();
    ser({1'b0, 32'hf6f69abc, 4'h0}, 37);
    frame_chk(0, 4'h0, 4'h0, 2'b00);
    // Stalled sink: buffer overflows, then drains
    reg_wr(8'hd4, 8'h00);
    stall <= 1'b1;
    from = rfa_framer_model_i.q.size();
    ser({10{4'h5}}, 40);
    ser({10{4'h5}}, 40);
    reg_rd(8'hb9, v);
    check("overflow flag", v, 8'h02);
    reg_wr(8'hb9, 8'h02);
    reg_rd(8'hb9, v);
    check("overflow cleared", v, 8'h00);
    stall <= 1'b0;
    repeat (40) @(posedge clk);
    // Boundary entered this burst one bit in, so kept words read 1010
    check("drained nibble", {4'h0, rfa_framer_model_i.q[$][3:0]}, 8'h0a);
    check("parity off", {7'h0, rfa_framer_model_i.q[$][4]}, 8'h00);
    check("words dropped", {7'h0, (rfa_framer_model_i.q.size() - from) < 20}, 8'h01);
    stop_test;
  end
endmodule
`default_nettype wire
